//--- design/scf_config_bank.sv
// sense, calibration and output fault configuration bank behind the command port
//
// Functional notes
// R1: calibration words are linear-11, mantissa times two-power
// R2: inductance in microhenry, reset b23d, 0 to 100
// R3: stored inductance drives ripple current algorithm
// R4: trim levels offset setpoint by stored percent
// R5: filter bit 7 picks low-side state after overvoltage
// R6: fault after N+1 consecutive violations, N bits 3:0
// R7: filter byte, write protectable, reset 00, 6:4 unused
// R8: one gain for both sensors, reset ba00, 0.1..10
// R9: one offset for both sensors, reset 0, +-100
// R10: reported temperature is measured over gain plus offset
// R11: correction applied to current sense, both sensors
// R12: bit 7 selects internal or external temperature source
// R13: factor 100ppm per degree, resistance equation about 25
// R14: correction resets 27h, factor limited 0 to 63
// R15: violation run restarts when sample back in limits
`timescale 1ns/1ns
`default_nettype none
module scf_config_bank #(
    parameter int PHASES = 2
) (
    // clock, reset and freeze
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // command port from the transaction layer
    input wire logic [7:0] cmd_code_i,
    input wire logic cmd_wr_i,
    input wire logic [15:0] cmd_wdata_i,
    input wire logic cmd_rd_i,
    input wire logic write_protect_i,
    output logic [15:0] cmd_rdata_o,
    output logic cmd_rvalid_o,
    output logic cmd_error_o,
    // user feature setup
    input wire logic margin_enable_i,
    input wire logic ext_sense_enable_i,
    input wire logic [15:0] nominal_output_setpoint_i,
    // temperatures, signed with 8 fraction bits, and current sense gain
    input wire logic [15:0] ext_sense_pin_a_i,
    input wire logic [15:0] ext_sense_pin_b_i,
    input wire logic [15:0] internal_temp_i,
    input wire logic [15:0] current_sense_gain_i,
    // output voltage limit samples
    input wire logic sample_valid_i,
    input wire logic ov_violation_i,
    input wire logic uv_violation_i,
    input wire logic fault_clear_i,
    // configuration results
    output logic [31:0] inductance_q16_o,
    output logic [15:0] upper_trim_level_o,
    output logic [15:0] lower_trim_level_o,
    output logic [15:0] reported_temp_a_o,
    output logic [15:0] reported_temp_b_o,
    output logic [15:0] sense_element_resistance_a_o,
    output logic [15:0] sense_element_resistance_b_o,
    // fault results
    output logic ov_fault_o,
    output logic uv_fault_o,
    output logic ov_shutdown_o,
    output logic low_side_on_o
);
    // every flip-flop of the bank outside the two violation filters
    typedef struct packed {
        logic [15:0] inductance_setting;
        logic [15:0] output_trim_percent;
        logic [7:0] output_fault_filter;
        logic [15:0] ext_temp_gain;
        logic [15:0] ext_temp_offset;
        logic [7:0] sense_temp_correction;
        logic [15:0] rdata;
        logic rvalid;
        logic error;
        logic [31:0] ind_q16;
        logic [15:0] upper;
        logic [15:0] lower;
        logic [PHASES-1:0][15:0] rep_temp;
        logic [PHASES-1:0][15:0] sense_res;
        logic ov_shut;
        logic low_side;
    } scf_bank_state_t;

    scf_bank_state_t state;
    scf_bank_state_t next_state;

    // per-phase sensor pins and the two filter channels
    logic [PHASES-1:0][15:0] ext_temp;
    logic [1:0] viol;
    logic [1:0] fault;

    assign ext_temp = {ext_sense_pin_b_i, ext_sense_pin_a_i};
    assign viol = {uv_violation_i, ov_violation_i};

    // one violation filter per channel: 0 is overvoltage, 1 undervoltage
    for (genvar ch = 0; ch < 2; ch++) begin : g_filter
        scf_violation_filter #(
            .CNT_W(5)
        ) u_filter (
            .core_clk_i(core_clk_i),
            .sys_rst_i(sys_rst_i),
            .ce_i(ce_i),
            .sample_valid_i(sample_valid_i),
            .violation_i(viol[ch]),
            .threshold_i(state.output_fault_filter[scf_pkg::SCF_FILTER_N_MSB:0]), // R6
            .fault_o(fault[ch])
        );
    end

    // command decode, range checks and all derived values
    always_comb begin
        logic signed [47:0] wval;
        logic signed [47:0] gain_q16;
        logic signed [47:0] ofs_q8;
        logic signed [47:0] pct_q16;
        logic signed [47:0] delta;
        logic signed [47:0] sum;
        logic signed [47:0] t_q8;
        logic signed [47:0] scaled;
        logic signed [47:0] corr;
        logic signed [47:0] sens_gain;
        logic ok;
        logic [15:0] rd;
        wval = scf_pkg::scf_lin11_q16(cmd_wdata_i); // R1
        gain_q16 = scf_pkg::scf_lin11_q16(state.ext_temp_gain);
        ofs_q8 = scf_pkg::scf_lin11_q16(state.ext_temp_offset) >>> scf_pkg::SCF_TEMP_FRAC;
        pct_q16 = scf_pkg::scf_lin11_q16(state.output_trim_percent);
        delta = '0;
        sum = '0;
        t_q8 = '0;
        scaled = '0;
        corr = '0;
        sens_gain = 48'(current_sense_gain_i);
        ok = 1'b1;
        rd = scf_pkg::SCF_ZERO16;
        next_state = state;
        next_state.rvalid = 1'b0;
        next_state.error = 1'b0;

        // writes: protected, unmapped or out of range leave the register alone
        if (cmd_wr_i) begin
            if (write_protect_i) begin
                ok = 1'b0; // R7
            end else begin
                case (cmd_code_i)
                    scf_pkg::SCF_CMD_INDUCTANCE: begin
                        ok = (wval >= 0) && (wval <= scf_pkg::SCF_IND_MAX); // R2
                        if (ok) next_state.inductance_setting = cmd_wdata_i;
                    end
                    scf_pkg::SCF_CMD_TRIM_PCT: begin
                        ok = (wval >= 0) && (wval <= scf_pkg::SCF_PCT_MAX); // R4
                        if (ok) next_state.output_trim_percent = cmd_wdata_i;
                    end
                    scf_pkg::SCF_CMD_FAULT_FILTER: begin
                        // unused bits 6:4 are dropped so they read back as zero
                        next_state.output_fault_filter =
                            cmd_wdata_i[7:0] & scf_pkg::SCF_FILTER_MASK; // R7
                    end
                    scf_pkg::SCF_CMD_EXT_GAIN: begin
                        ok = (wval >= scf_pkg::SCF_GAIN_MIN)
                            && (wval <= scf_pkg::SCF_GAIN_MAX); // R8
                        if (ok) next_state.ext_temp_gain = cmd_wdata_i;
                    end
                    scf_pkg::SCF_CMD_EXT_OFFSET: begin
                        ok = (wval >= -scf_pkg::SCF_OFS_MAX)
                            && (wval <= scf_pkg::SCF_OFS_MAX); // R9
                        if (ok) next_state.ext_temp_offset = cmd_wdata_i;
                    end
                    scf_pkg::SCF_CMD_TEMP_CORR: begin
                        ok = cmd_wdata_i[scf_pkg::SCF_CORR_FAC_MSB:0]
                            <= scf_pkg::SCF_FAC_MAX; // R14
                        if (ok) next_state.sense_temp_correction = cmd_wdata_i[7:0];
                    end
                    default: begin
                        ok = 1'b0;
                    end
                endcase
            end
            next_state.error = !ok;
        end

        // reads answer one cycle later; byte registers in the low bits
        if (cmd_rd_i) begin
            case (cmd_code_i)
                scf_pkg::SCF_CMD_INDUCTANCE: rd = state.inductance_setting;
                scf_pkg::SCF_CMD_TRIM_PCT: rd = state.output_trim_percent;
                scf_pkg::SCF_CMD_FAULT_FILTER: rd = {8'h00, state.output_fault_filter};
                scf_pkg::SCF_CMD_EXT_GAIN: rd = state.ext_temp_gain;
                scf_pkg::SCF_CMD_EXT_OFFSET: rd = state.ext_temp_offset;
                scf_pkg::SCF_CMD_TEMP_CORR: rd = {8'h00, state.sense_temp_correction};
                default: begin
                    // unmapped code reads zero and flags an error
                    rd = scf_pkg::SCF_ZERO16;
                    next_state.error = 1'b1;
                end
            endcase
            next_state.rvalid = 1'b1;
            next_state.rdata = rd;
        end

        // inductance handed to the ripple current algorithm in q16
        next_state.ind_q16 = 32'(scf_pkg::scf_lin11_q16(state.inductance_setting)); // R3

        // margining: setpoint plus and minus setpoint times percent over 100
        delta = (48'(nominal_output_setpoint_i) * pct_q16) / scf_pkg::SCF_PCT_DIV; // R4
        if (margin_enable_i) begin
            sum = 48'(nominal_output_setpoint_i) + delta;
            next_state.upper = (sum > 48'(scf_pkg::SCF_SAT16)) ? scf_pkg::SCF_SAT16
                : 16'(sum);
            sum = 48'(nominal_output_setpoint_i) - delta;
            next_state.lower = (sum < 0) ? scf_pkg::SCF_ZERO16 : 16'(sum);
        end else begin
            next_state.upper = nominal_output_setpoint_i;
            next_state.lower = nominal_output_setpoint_i;
        end

        // per phase: calibrated report and sense element resistance
        for (int ph = 0; ph < PHASES; ph++) begin
            // one gain and one offset serve every external sensor
            scaled = (48'($signed(ext_temp[ph])) <<< scf_pkg::SCF_Q_FRAC) / gain_q16; // R10
            next_state.rep_temp[ph] = 16'(scaled + ofs_q8); // R8 R9
            // external source only counts while external sensing is enabled
            if (state.sense_temp_correction[scf_pkg::SCF_CORR_SRC_BIT]
                    && ext_sense_enable_i) begin
                t_q8 = 48'($signed(next_state.rep_temp[ph])); // R12 R11
            end else begin
                t_q8 = 48'($signed(internal_temp_i)); // R12
            end
            // gain times (1 + factor times 100ppm times (t - 25)), signed for t below 25
            corr = sens_gain
                * $signed(48'(state.sense_temp_correction[scf_pkg::SCF_CORR_FAC_MSB:0]))
                * (t_q8 - scf_pkg::SCF_TREF_Q8) / scf_pkg::SCF_FAC_DIV; // R13
            sum = sens_gain + corr;
            next_state.sense_res[ph] = (sum < 0) ? scf_pkg::SCF_ZERO16
                : (sum > 48'(scf_pkg::SCF_SAT16)) ? scf_pkg::SCF_SAT16 : 16'(sum);
        end

        // overvoltage shutdown latch; a new fault beats a clear
        if (fault[0]) begin
            next_state.ov_shut = 1'b1;
        end else if (fault_clear_i) begin
            next_state.ov_shut = 1'b0;
        end
        next_state.low_side = next_state.ov_shut
            && next_state.output_fault_filter[scf_pkg::SCF_FILTER_LS_BIT]; // R5
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= '0;
            state.inductance_setting <= scf_pkg::SCF_RST_INDUCTANCE; // R2
            state.output_trim_percent <= scf_pkg::SCF_RST_TRIM_PCT; // R4
            state.output_fault_filter <= scf_pkg::SCF_RST_FAULT_FILTER; // R7
            state.ext_temp_gain <= scf_pkg::SCF_RST_EXT_GAIN; // R8
            state.ext_temp_offset <= scf_pkg::SCF_RST_EXT_OFFSET; // R9
            state.sense_temp_correction <= scf_pkg::SCF_RST_TEMP_CORR; // R14
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    // outputs straight from the state register, faults from the filters
    assign cmd_rdata_o = state.rdata;
    assign cmd_rvalid_o = state.rvalid;
    assign cmd_error_o = state.error;
    assign inductance_q16_o = state.ind_q16;
    assign upper_trim_level_o = state.upper;
    assign lower_trim_level_o = state.lower;
    assign reported_temp_a_o = state.rep_temp[0];
    assign reported_temp_b_o = state.rep_temp[1];
    assign sense_element_resistance_a_o = state.sense_res[0];
    assign sense_element_resistance_b_o = state.sense_res[1];
    assign ov_fault_o = fault[0];
    assign uv_fault_o = fault[1];
    assign ov_shutdown_o = state.ov_shut;
    assign low_side_on_o = state.low_side;
endmodule : scf_config_bank
`default_nettype wire

//--- design/scf_pkg.sv
// constants, register map and linear-11 helper for the sense, calibration and fault config bank
package scf_pkg;
    // command codes of the bank
    localparam logic [7:0] SCF_CMD_INDUCTANCE = 8'hd6;
    localparam logic [7:0] SCF_CMD_TRIM_PCT = 8'hd7;
    localparam logic [7:0] SCF_CMD_FAULT_FILTER = 8'hd8;
    localparam logic [7:0] SCF_CMD_EXT_GAIN = 8'hd9;
    localparam logic [7:0] SCF_CMD_EXT_OFFSET = 8'hda;
    localparam logic [7:0] SCF_CMD_TEMP_CORR = 8'hdc;

    // reset values
    localparam logic [15:0] SCF_RST_INDUCTANCE = 16'hb23d;
    localparam logic [15:0] SCF_RST_TRIM_PCT = 16'hca80;
    localparam logic [7:0] SCF_RST_FAULT_FILTER = 8'h00;
    localparam logic [15:0] SCF_RST_EXT_GAIN = 16'hba00;
    localparam logic [15:0] SCF_RST_EXT_OFFSET = 16'h0000;
    localparam logic [7:0] SCF_RST_TEMP_CORR = 8'h27;

    // field positions
    localparam int SCF_FILTER_LS_BIT = 7;
    localparam int SCF_FILTER_N_MSB = 3;
    localparam int SCF_FILTER_USED_MASK_MSB = 7;
    localparam logic [7:0] SCF_FILTER_MASK = 8'h8f;
    localparam int SCF_CORR_SRC_BIT = 7;
    localparam int SCF_CORR_FAC_MSB = 6;
    localparam int SCF_L11_EXP_LSB = 11;
    localparam int SCF_L11_MANT_MSB = 10;

    // fixed point: decoded values carry 16 fraction bits, temperatures 8
    localparam logic [5:0] SCF_Q_SHIFT = 6'h10;
    localparam int SCF_TEMP_FRAC = 8;
    localparam int SCF_Q_FRAC = 16;

    // permitted ranges, in q16 except the raw correction factor limit
    localparam logic signed [47:0] SCF_IND_MAX = 48'sh0000_0064_0000;
    localparam logic signed [47:0] SCF_PCT_MAX = 48'sh0000_0032_0000;
    localparam logic signed [47:0] SCF_GAIN_MIN = 48'sh0000_0000_199a;
    localparam logic signed [47:0] SCF_GAIN_MAX = 48'sh0000_000a_0000;
    localparam logic signed [47:0] SCF_OFS_MAX = 48'sh0000_0064_0000;
    localparam logic [6:0] SCF_FAC_MAX = 7'h3f;

    // arithmetic constants
    localparam logic signed [47:0] SCF_PCT_DIV = 48'sh0000_0064_0000;
    localparam logic signed [47:0] SCF_TREF_Q8 = 48'sh0000_0000_1900;
    localparam logic signed [47:0] SCF_FAC_DIV = 48'sh0000_0027_1000;
    localparam logic [15:0] SCF_SAT16 = 16'hffff;
    localparam logic [15:0] SCF_ZERO16 = 16'h0000;

    // linear-11 word to signed q16: mantissa shifted by exponent plus 16
    function automatic logic signed [47:0] scf_lin11_q16(input logic [15:0] word);
        logic signed [47:0] mant;
        logic [5:0] sh;
        mant = 48'($signed(word[SCF_L11_MANT_MSB:0]));
        sh = 6'({word[15], word[15:SCF_L11_EXP_LSB]}) + SCF_Q_SHIFT;
        return mant <<< sh;
    endfunction : scf_lin11_q16
endpackage : scf_pkg

//--- design/scf_violation_filter.sv
// consecutive limit violation counter for one fault channel
`timescale 1ns/1ns
`default_nettype none
module scf_violation_filter #(
    parameter int CNT_W = 5
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // samples
    input wire logic sample_valid_i,
    input wire logic violation_i,
    input wire logic [3:0] threshold_i,
    // result
    output logic fault_o
);
    // count of the current uninterrupted run, plus the fault pulse
    typedef struct packed {
        logic [CNT_W-1:0] run;
        logic fault;
    } scf_filter_state_t;

    scf_filter_state_t state;
    scf_filter_state_t next_state;

    // run counting; saturates one past the threshold so one run fires once
    always_comb begin
        next_state = state;
        next_state.fault = 1'b0;
        if (sample_valid_i) begin
            if (!violation_i) begin
                // back inside limits: the run is broken
                next_state.run = '0; // R15
            end else if (state.run == CNT_W'(threshold_i)) begin
                // this is violation N+1
                next_state.fault = 1'b1; // R6
                next_state.run = state.run + CNT_W'(1);
            end else if (state.run < CNT_W'(threshold_i)) begin
                next_state.run = state.run + CNT_W'(1);
            end
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= '0;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    assign fault_o = state.fault;
endmodule : scf_violation_filter
`default_nettype wire

//--- dv/scf_config_bank_properties.sv
// checker for the command port and the output fault path of the config bank
`timescale 1ns/1ns
`default_nettype none
module scf_config_bank_checker (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // command port
    input wire logic [7:0] cmd_code_i,
    input wire logic cmd_wr_i,
    input wire logic [15:0] cmd_wdata_i,
    input wire logic cmd_rd_i,
    input wire logic write_protect_i,
    input wire logic [15:0] cmd_rdata_o,
    input wire logic cmd_rvalid_o,
    input wire logic cmd_error_o,
    // fault path
    input wire logic sample_valid_i,
    input wire logic ov_violation_i,
    input wire logic uv_violation_i,
    input wire logic ov_fault_o,
    input wire logic uv_fault_o,
    input wire logic ov_shutdown_o,
    input wire logic low_side_on_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [7:0] filt; // shadow of the filter byte
    logic [4:0] ov_run; // consecutive ov samples
    logic [4:0] uv_run; // consecutive uv samples
    logic mapped; // code is one of the bank
    logic take; // a sample is counted
    assign mapped = cmd_code_i inside {8'hd6, 8'hd7, 8'hd8, 8'hd9, 8'hda, 8'hdc};
    assign take = ce_i && sample_valid_i;
    // shadow and run counters; saturate so a long run never wraps back onto the threshold
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            filt <= 8'h00;
            ov_run <= 5'h00;
            uv_run <= 5'h00;
        end else begin
            if (ce_i && cmd_wr_i && !write_protect_i && cmd_code_i == 8'hd8) begin
                filt <= cmd_wdata_i[7:0] & 8'h8f;
            end
            if (take) begin
                ov_run <= !ov_violation_i ? 5'h00 : (&ov_run ? ov_run : ov_run + 5'h01);
                uv_run <= !uv_violation_i ? 5'h00 : (&uv_run ? uv_run : uv_run + 5'h01);
            end
        end
    end
    rd_answer_a: assert property (ce_i && cmd_rd_i |=> cmd_rvalid_o) else $error("read lost");
    rvalid_cause_a: assert property (cmd_rvalid_o && $past(ce_i) |-> $past(cmd_rd_i))
        else $error("rv");
    rdata_hold_a: assert property (!cmd_rvalid_o |-> $stable(cmd_rdata_o)) else $error("rdata");
    wp_refuse_a: assert property (ce_i && cmd_wr_i && write_protect_i |=> cmd_error_o)
        else $error("protected write not refused");
    unmapped_read_a: assert property (ce_i && cmd_rd_i && !mapped |=> cmd_error_o
        && cmd_rdata_o == 16'h0000) else $error("unmapped read");
    ov_count_a: assert property (ov_fault_o |-> ov_run == 5'(filt[3:0]) + 5'h01)
        else $error("ov fault at wrong count");
    ov_fire_a: assert property (take && ov_violation_i && ov_run == 5'(filt[3:0])
        |=> ov_fault_o) else $error("ov fault missing");
    uv_count_a: assert property (uv_fault_o |-> uv_run == 5'(filt[3:0]) + 5'h01)
        else $error("uv fault at wrong count");
    shut_set_a: assert property (ov_fault_o && ce_i |=> ov_shutdown_o)
        else $error("no shutdown");
    shut_cause_a: assert property (!ov_shutdown_o && !ov_fault_o |=> !ov_shutdown_o)
        else $error("spurious shutdown");
    low_side_a: assert property (ov_shutdown_o && $past(ov_shutdown_o) && $stable(filt)
        |-> low_side_on_o == filt[7]) else $error("low side state");
    cover property (ov_fault_o);
    cover property (uv_fault_o);
    cover property (low_side_on_o);
    cover property (cmd_error_o);
endmodule : scf_config_bank_checker
bind scf_config_bank scf_config_bank_checker u_chk (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .ce_i(ce_i), .cmd_code_i(cmd_code_i), .cmd_wr_i(cmd_wr_i),
    .cmd_wdata_i(cmd_wdata_i), .cmd_rd_i(cmd_rd_i), .write_protect_i(write_protect_i),
    .cmd_rdata_o(cmd_rdata_o), .cmd_rvalid_o(cmd_rvalid_o), .cmd_error_o(cmd_error_o),
    .sample_valid_i(sample_valid_i), .ov_violation_i(ov_violation_i),
    .uv_violation_i(uv_violation_i), .ov_fault_o(ov_fault_o), .uv_fault_o(uv_fault_o),
    .ov_shutdown_o(ov_shutdown_o), .low_side_on_o(low_side_on_o));
`default_nettype wire

//--- dv/scf_host_model.sv
// host model issuing one-cycle read and write commands to the bank
`timescale 1ns/1ns
`default_nettype none
module scf_host_model (
    // clock
    input wire logic core_clk_i,
    // command port towards the bank
    output logic [7:0] cmd_code_o,
    output logic cmd_wr_o,
    output logic [15:0] cmd_wdata_o,
    output logic cmd_rd_o,
    input wire logic [15:0] cmd_rdata_i,
    input wire logic cmd_rvalid_i,
    input wire logic cmd_error_i
);
    // idle at time zero
    initial begin
        {cmd_code_o, cmd_wr_o, cmd_wdata_o, cmd_rd_o} = '0;
    end
    // one strobe cycle; on release the strobes drop and code and data are inverted so stale values cannot pass
    task automatic strobe(input logic [7:0] c, input logic [15:0] d, input logic is_rd);
        @(negedge core_clk_i);
        cmd_code_o = c;
        cmd_wdata_o = d;
        cmd_wr_o = !is_rd;
        cmd_rd_o = is_rd;
        @(negedge core_clk_i);
        cmd_wr_o = 1'b0;
        cmd_rd_o = 1'b0;
        cmd_code_o = ~c;
        cmd_wdata_o = ~d;
    endtask : strobe
    // write, answer error is seen in the cycle after the strobe
    task automatic wr(input logic [7:0] c, input logic [15:0] d, output logic e);
        strobe(c, d, 1'b0);
        e = cmd_error_i;
    endtask : wr
    // read, data and valid stand in the cycle after the strobe
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
        strobe(c, 16'h5a5a, 1'b1);
        d = cmd_rdata_i;
        v = cmd_rvalid_i;
    endtask : rd
endmodule : scf_host_model
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the config bank with the host model on its command port
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [7:0] CODES [6] = '{8'hd6, 8'hd7, 8'hd8, 8'hd9, 8'hda, 8'hdc};
    localparam logic [15:0] RSTV [6] = '{16'hb23d, 16'hca80, 16'h0000, 16'hba00, 16'h0000,
        16'h0027};
    logic core_clk_i = 1'b0; // 250 MHz
    logic sys_rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wp = 1'b0, men = 1'b0, xen = 1'b0, sv = 1'b0, ov = 1'b0, uv = 1'b0, fclr = 1'b0;
    logic [15:0] sp = 16'h03e8, pa = 16'h3200, pb = 16'h4600, ti = 16'h1900, g = 16'h03e8;
    logic [7:0] code;
    logic wr, rd, rv, er, ovf, uvf, shut, lso;
    logic [15:0] wd, rdat, up, lo, ta, tb2, ra, rb;
    logic [31:0] ind;
    int errors = 0, checked = 0, ov_seen = 0, uv_seen = 0;
    always #2 core_clk_i = ~core_clk_i;
    // fault pulses counted mid-pulse, clear of the launching edge
    always @(negedge core_clk_i) begin
        ov_seen += (ovf === 1'b1);
        uv_seen += (uvf === 1'b1);
    end
    scf_host_model host (.core_clk_i(core_clk_i), .cmd_code_o(code), .cmd_wr_o(wr),
        .cmd_wdata_o(wd), .cmd_rd_o(rd), .cmd_rdata_i(rdat), .cmd_rvalid_i(rv), .cmd_error_i(er));
    scf_config_bank #(.PHASES(2)) uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .ce_i(ce_i), .cmd_code_i(code), .cmd_wr_i(wr), .cmd_wdata_i(wd), .cmd_rd_i(rd),
        .write_protect_i(wp), .cmd_rdata_o(rdat), .cmd_rvalid_o(rv), .cmd_error_o(er),
        .margin_enable_i(men), .ext_sense_enable_i(xen), .nominal_output_setpoint_i(sp),
        .ext_sense_pin_a_i(pa), .ext_sense_pin_b_i(pb), .internal_temp_i(ti),
        .current_sense_gain_i(g), .sample_valid_i(sv), .ov_violation_i(ov),
        .uv_violation_i(uv), .fault_clear_i(fclr), .inductance_q16_o(ind),
        .upper_trim_level_o(up), .lower_trim_level_o(lo), .reported_temp_a_o(ta),
        .reported_temp_b_o(tb2), .sense_element_resistance_a_o(ra),
        .sense_element_resistance_b_o(rb), .ov_fault_o(ovf), .uv_fault_o(uvf),
        .ov_shutdown_o(shut), .low_side_on_o(lso));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        host.rd(c, d, v);
        chk("rdata", d, exp);
        chk("rvalid", v, 1'b1);
    endtask : rd_chk
    task automatic wr_chk(input logic [7:0] c, input logic [15:0] d, input logic ee);
        logic e;
        host.wr(c, d, e);
        chk("write error", e, ee);
    endtask : wr_chk
    // derived outputs lag by a cycle; three falling edges leave margin
    task automatic settle();
        repeat (3) @(negedge core_clk_i);
    endtask : settle
    task automatic smp(input logic o, input logic u);
        @(negedge core_clk_i);
        {sv, ov, uv} = {1'b1, o, u};
        @(negedge core_clk_i);
        sv = 1'b0;
    endtask : smp
    task automatic t_reset();
        for (int i = 0; i < 6; i++) begin
            rd_chk(CODES[i], RSTV[i]);
        end
        chk("inductance", ind, 32'h0000_8f40);
    endtask : t_reset
    task automatic t_trim();
        settle();
        chk("upper off", up, 16'h03e8);
        men = 1'b1;
        settle();
        chk("upper", up, 16'h041a);
        chk("lower", lo, 16'h03b6);
        wr_chk(8'hd7, 16'h0033, 1'b1);
        wr_chk(8'hd7, 16'h0032, 1'b0);
        settle();
        chk("upper 50", up, 16'h05dc);
        chk("lower 50", lo, 16'h01f4);
    endtask : t_trim
    task automatic t_rw();
        wr_chk(8'hd8, 16'h00ff, 1'b0);
        rd_chk(8'hd8, 16'h008f);
        wr_chk(8'hdc, 16'h0040, 1'b1);
        rd_chk(8'hdc, 16'h0027);
        wr_chk(8'hd6, 16'h0065, 1'b1);
        wr_chk(8'hd6, 16'h0064, 1'b0);
        wr_chk(8'hd9, 16'h000b, 1'b1);
        wr_chk(8'hda, 16'h0065, 1'b1);
        wp = 1'b1;
        wr_chk(8'hd8, 16'h0001, 1'b1);
        {wp, ce_i} = 2'b00;
        wr_chk(8'hd8, 16'h0002, 1'b1);
        ce_i = 1'b1;
        rd_chk(8'hd8, 16'h008f);
        rd_chk(8'hdb, 16'h0000);
        chk("unmapped error", er, 1'b1);
        chk("inductance 100", ind, 32'h0064_0000);
    endtask : t_rw
    task automatic t_temp();
        chk("temp a", ta, 16'h3200);
        chk("temp b", tb2, 16'h4600);
        wr_chk(8'hda, 16'h000a, 1'b0);
        wr_chk(8'hd9, 16'h0002, 1'b0);
        settle();
        chk("temp a cal", ta, 16'h2300);
        chk("temp b cal", tb2, 16'h2d00);
    endtask : t_temp
    task automatic t_sense_res();
        chk("res 25", ra, 16'h03e8);
        ti = 16'h7d00;
        settle();
        chk("res a 125", ra, 16'h056e);
        chk("res b 125", rb, 16'h056e);
        wr_chk(8'hdc, 16'h00a7, 1'b0);
        ti = 16'h0f00;
        settle();
        chk("res no ext 15", ra, 16'h03c1);
        xen = 1'b1;
        settle();
        chk("res ext a", ra, 16'h040f);
        chk("res ext b", rb, 16'h0436);
    endtask : t_sense_res
    task automatic t_fault();
        wr_chk(8'hd8, 16'h0081, 1'b0);
        ov_seen = 0;
        smp(1'b1, 1'b0);
        smp(1'b0, 1'b0);
        smp(1'b1, 1'b0);
        @(negedge core_clk_i);
        smp(1'b1, 1'b0);
        smp(1'b1, 1'b0);
        settle();
        chk("ov faults", ov_seen, 1);
        chk("shutdown", shut, 1'b1);
        chk("low side on", lso, 1'b1);
        fclr = 1'b1;
        settle();
        fclr = 1'b0;
        chk("shutdown cleared", shut, 1'b0);
        wr_chk(8'hd8, 16'h0003, 1'b0);
        smp(1'b0, 1'b0);
        repeat (3) smp(1'b1, 1'b1);
        settle();
        chk("ov three", ov_seen, 1);
        chk("uv three", uv_seen, 0);
        smp(1'b1, 1'b1);
        settle();
        chk("ov four", ov_seen, 2);
        chk("uv four", uv_seen, 1);
        chk("low side off", lso, 1'b0);
    endtask : t_fault
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    // reset for 16 cycles, then the scenarios in turn
    initial begin
        repeat (16) @(posedge core_clk_i);
        @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        t_reset();
        t_trim();
        t_rw();
        t_temp();
        t_sense_res();
        t_fault();
        end_of_test();
    end
    // watchdog, far beyond the roughly 120 cycles the scenarios take
    initial begin
        #40000;
        errors++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
